/* File: logic/twi_core_pkg.sv */
// Shared constants and types for the two-wire bus node and its peer.
// Assumes both ends meet through twi_link_if with open-drain pins.
// Overview of operation
// - Pins only pull low or release
// - Master clock keeps bit rate within limit
// - Node answers its own address only
// - Master starts, clocks and ends transfers
// - Master clocks and ends reads too
// - Addressed node is slave for that transfer
// - Driving one, seeing zero: arbitration lost
// - Winner's message reaches bus intact
// - Contending clocks combine by wired-AND
// - Tolerate slave stretch and clock sync
// - Several masters may share the bus
// - Start and stop are SDA edges, SCL high
// - SDA changes only while SCL low
// - Eight bits MSB first, then acknowledge
// - Transmitter releases, receiver pulls ack low; the master reader releases the ack slot (nack) instead
package twi_core_pkg;
  localparam int LINK_PERIOD_NS = 80;
  localparam int BIT_RATE_BPS = 100_000;
  localparam int BIT_NS = 1_000_000_000 / BIT_RATE_BPS;
  localparam int HALF_NS = BIT_NS / 2;
  // Least time per phase, so round up
  localparam int HALF_CYC = (HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_STEP = 8'h01;
  localparam int ADDR_W = 7;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_SLOT = 4'h9;
  localparam logic [3:0] SLOT_STEP = 4'h1;
  localparam logic [2:0] MSB_IDX = 3'h7;
  typedef enum logic [2:0] {M_IDLE, M_FREE, M_START, M_LOW, M_WAIT, M_HIGH, M_STOP} mst_t;
endpackage

/* File: logic/twi_link_if.sv */
// Two-wire bus carrier joining the node and its peer.
// Assumes each end drives only an output and an enable per line.
`timescale 1ns/1ns
`default_nettype none
interface twi_link_if;
  logic node_scl_o;
  logic node_scl_oe;
  logic node_sda_o;
  logic node_sda_oe;
  logic peer_scl_o;
  logic peer_scl_oe;
  logic peer_sda_o;
  logic peer_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-up: high unless someone drives low
  assign scl = ~((node_scl_oe & ~node_scl_o) | (peer_scl_oe & ~peer_scl_o));
  assign sda = ~((node_sda_oe & ~node_sda_o) | (peer_sda_oe & ~peer_sda_o));
  modport node (input scl, input sda, output node_scl_o, output node_scl_oe,
                output node_sda_o, output node_sda_oe);
  modport peer (input scl, input sda, output peer_scl_o, output peer_scl_oe,
                output peer_sda_o, output peer_sda_oe);
endinterface
`default_nettype wire

/* File: logic/twi_peer_slave.sv */
// Far end: a slave-only bus device on its own clock.
// Assumes a master elsewhere creates start, clock and stop.
`timescale 1ns/1ns
`default_nettype none
module twi_peer_slave #(
  parameter logic [twi_core_pkg::ADDR_W-1:0] PEER_ADDR = 7'h21
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Bus
  twi_link_if.peer BUS,
  // User side
  input wire logic STRETCH,
  input wire logic [7:0] TX_DATA,
  output logic RX_VALID,
  output logic [7:0] RX_DATA,
  output logic ADDRESSED
);
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic busy, past, match, rw, send, hold, sda_low, rxv;
    logic [3:0] bitn;
    logic [7:0] sh, tx, rxd;
  } peer_t;
  peer_t q, d;

  // Observer, slave answer and stretch
  always_comb begin
    logic rise, fall, past_n;
    logic [3:0] nb;
    logic [7:0] nsh;
    rise = 1'b0;
    fall = 1'b0;
    past_n = 1'b0;
    nb = 4'h0;
    nsh = 8'h00;
    d = q;
    d.rxv = 1'b0;
    d.scl_m = BUS.scl;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = BUS.sda;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    rise = q.busy & q.scl_s & ~q.scl_p;
    fall = q.busy & ~q.scl_s & q.scl_p;
    nsh = {q.sh[6:0], q.sda_s};
    nb = (q.bitn == twi_core_pkg::LAST_SLOT) ? 4'h0 : q.bitn;
    past_n = q.past | (q.bitn == twi_core_pkg::LAST_SLOT);
    if (q.scl_s & q.scl_p & q.sda_p & ~q.sda_s) begin
      d.busy = 1'b1;
      d.bitn = 4'h0;
      d.past = 1'b0;
      d.match = 1'b0;
      d.send = 1'b0;
      d.sda_low = 1'b0;
    end else if (q.scl_s & q.scl_p & ~q.sda_p & q.sda_s) begin
      d.busy = 1'b0;
      d.match = 1'b0;
      d.send = 1'b0;
      d.sda_low = 1'b0;
    end else if (rise) begin
      d.bitn = q.bitn + twi_core_pkg::SLOT_STEP;
      if (q.bitn < twi_core_pkg::ACK_SLOT) begin
        d.sh = nsh;
      end
      if (q.bitn == twi_core_pkg::LAST_DATA && !q.past) begin
        d.match = (nsh[7:1] == PEER_ADDR);
        d.rw = nsh[0];
      end else if (q.bitn == twi_core_pkg::LAST_DATA && q.match && !q.rw) begin
        d.rxd = nsh;
        d.rxv = 1'b1;
      end
      // Master nack ends the read
      if (q.bitn == twi_core_pkg::ACK_SLOT && q.send && q.sda_s) begin
        d.send = 1'b0;
      end
    end else if (fall) begin
      if (q.bitn == twi_core_pkg::LAST_SLOT) begin
        d.bitn = 4'h0;
        d.past = 1'b1;
        d.tx = TX_DATA;
        d.hold = q.match & STRETCH;
        if (q.match && q.rw && !q.past) begin
          d.send = 1'b1;
        end
      end
      if (nb == twi_core_pkg::ACK_SLOT) begin
        d.sda_low = q.match & ~(q.rw & past_n);
      end else begin
        d.sda_low = d.send & ~d.tx[twi_core_pkg::MSB_IDX - nb[2:0]];
      end
    end
    if (!STRETCH) begin
      d.hold = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign BUS.peer_scl_o = 1'b0;
  assign BUS.peer_sda_o = 1'b0;
  assign BUS.peer_scl_oe = q.hold;
  assign BUS.peer_sda_oe = q.sda_low;
  assign RX_VALID = q.rxv;
  assign RX_DATA = q.rxd;
  assign ADDRESSED = q.match;
endmodule
`default_nettype wire

/* File: logic/twi_node_core.sv */
// Multi-master bus node: master engine plus slave responder.
// Assumes LINK_CLK free-running; user side on SYS_CLK, toggle crossings.
`timescale 1ns/1ns
`default_nettype none
module twi_node_core #(
  parameter logic [twi_core_pkg::ADDR_W-1:0] OWN_ADDR = 7'h2A
) (
  // Clocks and reset
  input wire logic SYS_CLK,
  input wire logic LINK_CLK,
  input wire logic RESETN,
  // Bus
  twi_link_if.node BUS,
  // Request
  input wire logic REQ_VALID,
  input wire logic REQ_LOAD,
  input wire logic [twi_core_pkg::ADDR_W-1:0] REQ_ADDR,
  input wire logic REQ_RW,
  input wire logic [7:0] REQ_DATA,
  output logic REQ_READY,
  // Result
  output logic DONE,
  output logic DONE_ACK,
  output logic DONE_LOST,
  output logic [7:0] DONE_DATA,
  // Slave receive
  output logic RX_VALID,
  output logic [7:0] RX_DATA
);
  typedef struct packed {
    logic req_t, busy, load, rw, ready;
    logic [twi_core_pkg::ADDR_W-1:0] addr;
    logic [7:0] data;
    logic dn_m, dn_s, dn_p, rx_m, rx_s, rx_p;
    logic done, ack, lost, rxv;
    logic [7:0] ddata, rxd;
  } sys_t;
  typedef struct packed {
    logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
    logic rq_m, rq_s, rq_p, done_t, rx_t;
    logic busy, past, s_match, s_rw, s_send;
    logic [3:0] bitn;
    logic [7:0] rx_sh, rx_hold, slv_tx, s_tx;
    twi_core_pkg::mst_t mst;
    logic [twi_core_pkg::CNT_W-1:0] cnt;
    logic [7:0] m_addr, m_data, m_rd;
    logic m_ack_a, m_ack_d, m_lost, m_stp;
    logic scl_low, sda_low;
  } lnk_t;
  sys_t s_q, s_d;
  lnk_t l_q, l_d;

  // User side: request hand-off and result pick-up
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.rxv = 1'b0;
    s_d.dn_m = l_q.done_t;
    s_d.dn_s = s_q.dn_m;
    s_d.dn_p = s_q.dn_s;
    s_d.rx_m = l_q.rx_t;
    s_d.rx_s = s_q.rx_m;
    s_d.rx_p = s_q.rx_s;
    // Fields stay frozen while busy, so the link reads them unsynced
    if (REQ_VALID && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.req_t = ~s_q.req_t;
      s_d.load = REQ_LOAD;
      s_d.addr = REQ_ADDR;
      s_d.rw = REQ_RW;
      s_d.data = REQ_DATA;
    end
    if (s_q.dn_s != s_q.dn_p) begin
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
      s_d.ack = ~s_q.load & l_q.m_ack_a & (s_q.rw | l_q.m_ack_d);
      s_d.lost = ~s_q.load & l_q.m_lost;
      s_d.ddata = l_q.m_rd;
    end
    if (s_q.rx_s != s_q.rx_p) begin
      s_d.rxv = 1'b1;
      s_d.rxd = l_q.rx_hold;
    end
    s_d.ready = ~s_d.busy;
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Link side: observer, master timing, slave answer
  always_comb begin
    logic rise, fall, start_ev, stop_ev, m_act, lost, past_n;
    logic [3:0] nb;
    logic [7:0] nsh;
    rise = 1'b0;
    fall = 1'b0;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    m_act = 1'b0;
    lost = 1'b0;
    past_n = 1'b0;
    nb = 4'h0;
    nsh = 8'h00;
    l_d = l_q;
    l_d.scl_m = BUS.scl;
    l_d.scl_s = l_q.scl_m;
    l_d.scl_p = l_q.scl_s;
    l_d.sda_m = BUS.sda;
    l_d.sda_s = l_q.sda_m;
    l_d.sda_p = l_q.sda_s;
    l_d.rq_m = s_q.req_t;
    l_d.rq_s = l_q.rq_m;
    l_d.rq_p = l_q.rq_s;
    rise = l_q.busy & l_q.scl_s & ~l_q.scl_p;
    fall = l_q.busy & ~l_q.scl_s & l_q.scl_p;
    start_ev = l_q.scl_s & l_q.scl_p & l_q.sda_p & ~l_q.sda_s;
    stop_ev = l_q.scl_s & l_q.scl_p & ~l_q.sda_p & l_q.sda_s;
    m_act = (l_q.mst != twi_core_pkg::M_IDLE) && (l_q.mst != twi_core_pkg::M_FREE);
    nsh = {l_q.rx_sh[6:0], l_q.sda_s};
    nb = (l_q.bitn == twi_core_pkg::LAST_SLOT) ? 4'h0 : l_q.bitn;
    past_n = l_q.past | (l_q.bitn == twi_core_pkg::LAST_SLOT);
    // released a one, bus shows zero
    lost = rise & m_act & ~l_q.m_stp & (l_q.bitn < twi_core_pkg::ACK_SLOT)
           & ~l_q.sda_low & (~l_q.past | ~l_q.m_addr[0]) & ~l_q.sda_s;

    if (start_ev) begin
      l_d.busy = 1'b1;
      l_d.bitn = 4'h0;
      l_d.past = 1'b0;
      l_d.s_match = 1'b0;
      l_d.s_send = 1'b0;
    end else if (stop_ev) begin
      l_d.busy = 1'b0;
      l_d.s_match = 1'b0;
      l_d.s_send = 1'b0;
      if (!m_act) begin
        l_d.sda_low = 1'b0;
      end
    end else if (rise) begin
      // eight bits MSB first, ninth is ack
      l_d.bitn = l_q.bitn + twi_core_pkg::SLOT_STEP;
      if (l_q.bitn < twi_core_pkg::ACK_SLOT) begin
        l_d.rx_sh = nsh;
      end
      if (l_q.bitn == twi_core_pkg::LAST_DATA) begin
        if (!l_q.past) begin
          l_d.s_match = (nsh[7:1] == OWN_ADDR) & (~m_act | lost);
          l_d.s_rw = nsh[0];
        end else if (l_q.s_match && !l_q.s_rw) begin
          l_d.rx_hold = nsh;
          l_d.rx_t = ~l_q.rx_t;
        end
        if (m_act && l_q.past) begin
          l_d.m_rd = nsh;
        end
      end
      if (l_q.bitn == twi_core_pkg::ACK_SLOT) begin
        if (m_act && !l_q.past) begin
          l_d.m_ack_a = ~l_q.sda_s;
        end
        if (m_act && l_q.past) begin
          l_d.m_ack_d = ~l_q.sda_s;
        end
        if (l_q.s_send && l_q.sda_s) begin
          l_d.s_send = 1'b0;
        end
      end
    end else if (fall) begin
      if (l_q.bitn == twi_core_pkg::LAST_SLOT) begin
        l_d.bitn = 4'h0;
        l_d.past = 1'b1;
        l_d.s_tx = l_q.slv_tx;
        if (l_q.s_match && l_q.s_rw && !l_q.past) begin
          l_d.s_send = 1'b1;
        end
      end
      // data changes only after SCL falls
      if (m_act) begin
        if (l_q.bitn == twi_core_pkg::LAST_SLOT && (l_q.past || !l_q.m_ack_a)) begin
          l_d.sda_low = 1'b1;
          l_d.m_stp = 1'b1;
        end else if (nb == twi_core_pkg::ACK_SLOT) begin
          // release for ack; master reader sends nack
          l_d.sda_low = 1'b0;
        end else if (!past_n) begin
          l_d.sda_low = ~l_q.m_addr[twi_core_pkg::MSB_IDX - nb[2:0]];
        end else begin
          l_d.sda_low = ~l_q.m_addr[0] & ~l_q.m_data[twi_core_pkg::MSB_IDX - nb[2:0]];
        end
      end else if (l_q.s_match) begin
        if (nb == twi_core_pkg::ACK_SLOT) begin
          l_d.sda_low = ~(l_q.s_rw & past_n);
        end else begin
          l_d.sda_low = l_d.s_send & ~l_d.s_tx[twi_core_pkg::MSB_IDX - nb[2:0]];
        end
      end else begin
        l_d.sda_low = 1'b0;
      end
    end

    // half period counts cap the bit rate
    case (l_q.mst)
      twi_core_pkg::M_IDLE: begin
        if (l_q.rq_s != l_q.rq_p) begin
          if (s_q.load) begin
            l_d.slv_tx = s_q.data;
            l_d.done_t = ~l_q.done_t;
          end else begin
            l_d.m_addr = {s_q.addr, s_q.rw};
            l_d.m_data = s_q.data;
            l_d.m_ack_a = 1'b0;
            l_d.m_ack_d = 1'b0;
            l_d.m_lost = 1'b0;
            l_d.m_rd = 8'h00;
            l_d.mst = twi_core_pkg::M_FREE;
          end
        end
      end
      twi_core_pkg::M_FREE: begin
        // start only on a free bus
        if (!l_q.busy && l_q.scl_s && l_q.sda_s) begin
          l_d.sda_low = 1'b1;
          l_d.cnt = '0;
          l_d.mst = twi_core_pkg::M_START;
        end
      end
      twi_core_pkg::M_START: begin
        l_d.cnt = l_q.cnt + twi_core_pkg::CNT_STEP;
        if (l_q.cnt == twi_core_pkg::HALF_LAST) begin
          l_d.scl_low = 1'b1;
          l_d.cnt = '0;
          l_d.mst = twi_core_pkg::M_LOW;
        end
      end
      twi_core_pkg::M_LOW: begin
        l_d.cnt = l_q.cnt + twi_core_pkg::CNT_STEP;
        if (l_q.cnt == twi_core_pkg::HALF_LAST) begin
          l_d.scl_low = 1'b0;
          l_d.mst = twi_core_pkg::M_WAIT;
        end
      end
      twi_core_pkg::M_WAIT: begin
        // wait out a stretched or longer low
        if (l_q.scl_s) begin
          l_d.cnt = '0;
          l_d.mst = twi_core_pkg::M_HIGH;
        end
      end
      twi_core_pkg::M_HIGH: begin
        l_d.cnt = l_q.cnt + twi_core_pkg::CNT_STEP;
        if (!l_q.scl_s) begin
          // shortest high wins, restart low count
          l_d.scl_low = 1'b1;
          l_d.cnt = '0;
          l_d.mst = twi_core_pkg::M_LOW;
        end else if (l_q.cnt == twi_core_pkg::HALF_LAST) begin
          l_d.cnt = '0;
          if (l_q.m_stp) begin
            l_d.sda_low = 1'b0;
            l_d.mst = twi_core_pkg::M_STOP;
          end else begin
            l_d.scl_low = 1'b1;
            l_d.mst = twi_core_pkg::M_LOW;
          end
        end
      end
      twi_core_pkg::M_STOP: begin
        // Bus free time before reporting
        l_d.cnt = l_q.cnt + twi_core_pkg::CNT_STEP;
        if (l_q.cnt == twi_core_pkg::HALF_LAST) begin
          l_d.m_stp = 1'b0;
          l_d.done_t = ~l_q.done_t;
          l_d.mst = twi_core_pkg::M_IDLE;
        end
      end
      default: begin
        l_d.mst = twi_core_pkg::M_IDLE;
      end
    endcase

    // loser lets go at once, winner untouched
    if (lost) begin
      l_d.m_lost = 1'b1;
      l_d.scl_low = 1'b0;
      l_d.sda_low = 1'b0;
      l_d.m_stp = 1'b0;
      l_d.done_t = ~l_q.done_t;
      l_d.mst = twi_core_pkg::M_IDLE;
    end
  end

  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign BUS.node_scl_o = 1'b0;
  assign BUS.node_sda_o = 1'b0;
  assign BUS.node_scl_oe = l_q.scl_low;
  assign BUS.node_sda_oe = l_q.sda_low;
  assign REQ_READY = s_q.ready;
  assign DONE = s_q.done;
  assign DONE_ACK = s_q.ack;
  assign DONE_LOST = s_q.lost;
  assign DONE_DATA = s_q.ddata;
  assign RX_VALID = s_q.rxv;
  assign RX_DATA = s_q.rxd;
endmodule
`default_nettype wire

/* File: bench/twi_core_sva.sv */
// Checker for the bus that joins the node to the peer slave.
// Assumes the link clock samples both wired lines and the enables.
`timescale 1ns/1ns
`default_nettype none
module twi_core_sva (
  // Clock and reset
  input wire logic LINK_CLK,
  input wire logic RESETN,
  // Wired lines and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic node_scl_o,
  input wire logic node_sda_o,
  input wire logic node_scl_oe,
  input wire logic node_sda_oe,
  input wire logic peer_scl_oe
);
  // Two cycles of slack for the pin synchronisers
  localparam int MIN_PH = 60;
  logic [7:0] ph_cnt_q;
  logic [4:0] rise_cnt_q;
  logic scl_q;
  logic sda_q;
  logic rd_q;
  default clocking cb @(posedge LINK_CLK); endclocking
  default disable iff (!RESETN);
  // Phase length, clock rises since start, direction bit
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ph_cnt_q <= 8'h00;
      rise_cnt_q <= 5'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      ph_cnt_q <= (scl != scl_q) ? 8'h00 : ph_cnt_q + ((ph_cnt_q == 8'hFF) ? 8'h00 : 8'h01);
      if (scl && scl_q && sda_q && !sda) rise_cnt_q <= 5'h00;
      else if (scl && !scl_q) rise_cnt_q <= rise_cnt_q + 5'h01;
      if (scl && !scl_q && rise_cnt_q == 5'h07) rd_q <= sda;
    end
  end
  sequence start_seen; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_seen; scl && $past(scl) && $rose(sda); endsequence
  sequence first_low; scl[*8] ##[40:80] !scl; endsequence
  a_pull_low_only: assert property (!node_scl_o && !node_sda_o)
    else $error("node drives a line high");
  a_low_phase_min: assert property ($rose(scl) |-> ph_cnt_q >= MIN_PH)
    else $error("clock low phase too short");
  a_high_phase_min: assert property ($fell(scl) |-> ph_cnt_q >= MIN_PH)
    else $error("clock high phase too short");
  a_master_clocks: assert property ($fell(scl) |-> node_scl_oe)
    else $error("clock fall not made by master");
  a_start_then_clock: assert property (start_seen |=> first_low)
    else $error("start not followed by clocking");
  a_stop_bus_free: assert property (stop_seen |=> (scl && sda)[*8])
    else $error("bus not free after stop");
  a_stop_after_ack: assert property (stop_seen |-> rise_cnt_q == 5'h0A || rise_cnt_q == 5'h13)
    else $error("stop not after a whole byte and ack");
  a_data_stable_high: assert property (scl && $past(scl) && $changed(sda)
    |-> rise_cnt_q == 5'h00 || rise_cnt_q == 5'h0A || rise_cnt_q == 5'h13)
    else $error("data moved while clock high");
  a_ack_released: assert property ($rose(scl) && (rise_cnt_q == 5'h08 || rise_cnt_q == 5'h11)
    |-> !node_sda_oe)
    else $error("master holds data in ack slot");
  a_read_released: assert property ($rose(scl) && rd_q && rise_cnt_q >= 5'h0A
    && rise_cnt_q <= 5'h10 |-> !node_sda_oe)
    else $error("master drives data on a read");
  a_stretch_release: assert property ($fell(peer_scl_oe) |-> scl[*8])
    else $error("clock not high after stretch");
endmodule
`default_nettype wire

/* File: bench/two_wire_multimaster_bus_core_tb.sv */
// Bench: node against the peer slave, plus a lone node for arbitration.
// Assumes package, carrier and both design ends are compiled first.
`timescale 1ns/1ns
`default_nettype none
module two_wire_multimaster_bus_core_tb;
  localparam logic [6:0] PADDR = 7'h21;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid_a = 1'b0;
  logic req_valid_b = 1'b0;
  logic req_load = 1'b0;
  logic [6:0] req_addr = 7'h00;
  logic req_rw = 1'b0;
  logic [7:0] req_data = 8'h00;
  logic [7:0] peer_tx = 8'h00;
  logic stretch = 1'b0;
  logic ready_a, done_a, ack_a, lost_a, ready_b, done_b, ack_b, lost_b;
  logic peer_rx_v, peer_adr;
  logic rx_v_b;
  logic [7:0] rx_d_b;
  int rxb_cnt = 0;
  logic [7:0] dat_a, peer_rx_d;
  int n_mismatch = 0;
  int cmp_count = 0;
  int rx_cnt = 0;
  twi_link_if bus_a ();
  twi_link_if bus_b ();
  twi_node_core #(.OWN_ADDR(7'h2A)) i_twi_node_core (.SYS_CLK(sys_clk), .LINK_CLK(link_clk),
    .RESETN(resetn), .BUS(bus_a.node), .REQ_VALID(req_valid_a), .REQ_LOAD(req_load),
    .REQ_ADDR(req_addr), .REQ_RW(req_rw), .REQ_DATA(req_data), .REQ_READY(ready_a),
    .DONE(done_a), .DONE_ACK(ack_a), .DONE_LOST(lost_a), .DONE_DATA(dat_a), .RX_VALID(),
    .RX_DATA());
  twi_node_core #(.OWN_ADDR(7'h2A)) i_twi_node_core_b (.SYS_CLK(sys_clk), .LINK_CLK(link_clk),
    .RESETN(resetn), .BUS(bus_b.node), .REQ_VALID(req_valid_b), .REQ_LOAD(req_load),
    .REQ_ADDR(req_addr), .REQ_RW(req_rw), .REQ_DATA(req_data), .REQ_READY(ready_b),
    .DONE(done_b), .DONE_ACK(ack_b), .DONE_LOST(lost_b), .DONE_DATA(), .RX_VALID(rx_v_b),
    .RX_DATA(rx_d_b));
  twi_peer_slave #(.PEER_ADDR(PADDR)) i_twi_peer_slave (.SYS_CLK(sys_clk), .RESETN(resetn),
    .BUS(bus_a.peer), .STRETCH(stretch), .TX_DATA(peer_tx), .RX_VALID(peer_rx_v),
    .RX_DATA(peer_rx_d), .ADDRESSED(peer_adr));
  twi_core_sva i_twi_core_sva (.LINK_CLK(link_clk), .RESETN(resetn), .scl(bus_a.scl),
    .sda(bus_a.sda), .node_scl_o(bus_a.node_scl_o), .node_sda_o(bus_a.node_sda_o),
    .node_scl_oe(bus_a.node_scl_oe), .node_sda_oe(bus_a.node_sda_oe),
    .peer_scl_oe(bus_a.peer_scl_oe));
  // Clocks; link offset so its edges never meet the user clock
  always #50 sys_clk = ~sys_clk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  // Bytes the peer took in
  always @(posedge sys_clk) if (peer_rx_v === 1'b1) rx_cnt <= rx_cnt + 1;
  // Bytes node b took in as slave
  always @(posedge sys_clk) if (rx_v_b === 1'b1) rxb_cnt <= rxb_cnt + 1;
  function automatic logic exp_ack(input logic [6:0] a);
    return a == PADDR;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One request, then wait for its done pulse under a bound
  task automatic run(input logic sb, input logic ld, input logic [6:0] a, input logic r,
    input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    req_load <= ld;
    req_addr <= a;
    req_rw <= r;
    req_data <= d;
    peer_tx <= d;
    if (sb) req_valid_b <= 1'b1;
    else req_valid_a <= 1'b1;
    @(posedge sys_clk);
    req_valid_a <= 1'b0;
    req_valid_b <= 1'b0;
    @(negedge sys_clk);
    check(8'(sb ? ready_b : ready_a), 8'h00, "ready after take");
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while ((sb ? done_b : done_a) !== 1'b1 && n < 9000);
    if (n >= 9000) check(8'h00, 8'h01, "done timeout");
  endtask
  // Bench as rival master on bus b; half bit of 50 cycles keeps the rate limit
  task automatic bb_bit(input logic b, output logic got);
    @(posedge sys_clk);
    bus_b.peer_scl_oe <= 1'b1;
    repeat (10) @(posedge sys_clk);
    bus_b.peer_sda_oe <= ~b;
    repeat (40) @(posedge sys_clk);
    bus_b.peer_scl_oe <= 1'b0;
    repeat (25) @(posedge sys_clk);
    got = bus_b.sda;
    repeat (25) @(posedge sys_clk);
  endtask
  // Eight bits MSB first, then a released ack slot
  task automatic bb_byte(input logic [7:0] v, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bb_bit(v[i], g);
    bb_bit(1'b1, g);
    ack = ~g;
  endtask
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Watchdog well past ten full frames
  initial begin
    #6_000_000;
    n_mismatch++;
    finish_test();
  end
  initial begin
    logic [7:0] d;
    int base;
    logic g, ack_1, ack_2;
    bus_b.peer_scl_o = 1'b0;
    bus_b.peer_sda_o = 1'b0;
    bus_b.peer_scl_oe = 1'b0;
    bus_b.peer_sda_oe = 1'b0;
    void'($urandom(48));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    // Random write, then a read of a fresh random byte from the peer
    repeat (3) begin
      d = 8'($urandom);
      base = rx_cnt;
      run(1'b0, 1'b0, PADDR, 1'b0, d);
      check(8'(ack_a), 8'(exp_ack(PADDR)), "write ack");
      check(8'(lost_a), 8'h00, "write lost");
      check(peer_rx_d, d, "write data");
      check(8'(rx_cnt - base), 8'h01, "write count");
      d = 8'($urandom);
      run(1'b0, 1'b0, PADDR, 1'b1, d);
      check(dat_a, d, "read data");
      check(8'(ack_a), 8'h01, "read ack");
    end
    // Foreign address is left unanswered
    base = rx_cnt;
    run(1'b0, 1'b0, 7'($urandom) | 7'h40, 1'b0, 8'hA5);
    check(8'(ack_a), 8'h00, "nack seen");
    check(8'(rx_cnt - base), 8'h00, "no byte taken");
    // Slave holds the clock low long past a half bit
    d = 8'($urandom);
    @(posedge sys_clk);
    stretch <= 1'b1;
    fork
      run(1'b0, 1'b0, PADDR, 1'b0, d);
      begin
        wait (bus_a.peer_scl_oe === 1'b1);
        check(8'(peer_adr), 8'h01, "peer addressed");
        repeat (300) @(posedge sys_clk);
        check(8'(bus_a.scl), 8'h00, "clock stretched");
        stretch <= 1'b0;
      end
    join
    check(peer_rx_d, d, "stretched data");
    // Slave byte load does no bus work
    run(1'b0, 1'b1, 7'h00, 1'b0, 8'h3C);
    check(8'({ack_a, lost_a}), 8'h00, "load flags");
    // Rival pulls data low against a one: arbitration lost
    fork
      run(1'b1, 1'b0, 7'h7F, 1'b0, 8'hFF);
      begin
        wait (bus_b.node_scl_oe === 1'b1);
        @(posedge sys_clk);
        bus_b.peer_sda_oe <= 1'b1;
      end
    join
    check(8'(lost_b), 8'h01, "lost flag");
    check(8'(ack_b), 8'h00, "lost ack");
    check(8'({bus_b.node_scl_oe, bus_b.node_sda_oe}), 8'h00, "lines let go");
    @(posedge sys_clk);
    bus_b.peer_sda_oe <= 1'b0;
    repeat (20) @(posedge sys_clk);
    // Bench masters bus b: node b is the addressed slave receiver
    d = 8'($urandom);
    base = rxb_cnt;
    @(posedge sys_clk);
    bus_b.peer_sda_oe <= 1'b1;
    repeat (50) @(posedge sys_clk);
    bb_byte({7'h2A, 1'b0}, ack_1);
    bb_byte(d, ack_2);
    bb_bit(1'b0, g);
    @(posedge sys_clk);
    bus_b.peer_sda_oe <= 1'b0;
    repeat (50) @(posedge sys_clk);
    check(8'(ack_1), 8'h01, "slave address ack");
    check(8'(ack_2), 8'h01, "slave data ack");
    check(rx_d_b, d, "slave data");
    check(8'(rxb_cnt - base), 8'h01, "slave byte count");
    finish_test();
  end
endmodule
`default_nettype wire
